// ### rtl/clk_speed_pkg.sv
// constants for the double-speed clock control block
package clk_speed_pkg;
  // register offset: 0x8f is not a multiple of four, so it is an index
  localparam logic [7:0] CTRL_INDEX = 8'h8f;
  localparam logic [11:0] CTRL_ADDR = {2'h0, CTRL_INDEX, 2'h0};
  // field positions
  localparam int DOUBLE_BIT = 0;
  localparam int FIRST_TIMER_BIT = 1;
  localparam int SECOND_TIMER_BIT = 2;
  localparam int THIRD_TIMER_BIT = 3;
  localparam int SERIAL_BIT = 4;
  localparam int COUNTER_ARRAY_BIT = 5;
  localparam int WATCHDOG_BIT = 6;
  localparam int RESERVED_BIT = 7;
  localparam int NUM_PERIPH = 6;
  // reset value of all bits except the double-speed select
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_WRITE_MASK = 8'h7f;
  // periods per machine cycle
  localparam logic [3:0] STD_PERIODS = 4'hc;
  localparam logic [3:0] FAST_PERIODS = 4'h6;
  // htrans encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
endpackage

// ### rtl/osc_divider.sv
// divide-by-two oscillator stage with glitch-free bypass select
`timescale 1ns/1ps
module osc_divider (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic fast_req,
  output logic half_tick,
  output logic fast_active
);
  logic div_reg;
  logic div_next;
  logic fast_reg;
  logic fast_next;

  always_comb begin
    div_next = ~div_reg;
    fast_next = fast_reg;
    if (div_reg == 1'b0) begin
      fast_next = fast_req;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_reg <= 1'b0;
      fast_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      fast_reg <= fast_next;
    end
  end

  assign half_tick = fast_reg | div_reg;
  assign fast_active = fast_reg;

  // rising edge of the divided clock is when div_reg goes 0 to 1
  property p_switch_on_half_edge;
    @(posedge hclk) disable iff (!hresetn)
      (fast_reg != $past(fast_reg)) |-> $past(div_reg) == 1'b0;
  endproperty
  a_switch_on_half_edge: assert property (p_switch_on_half_edge)
    else $error("mode changed off the divided clock edge");
endmodule

// ### rtl/cycle_counter.sv
// machine cycle phase counter: 12 or 6 periods per cycle
`timescale 1ns/1ps
module cycle_counter (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic fast,
  output logic cycle_end
);
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic [3:0] limit;

  assign limit = fast ? clk_speed_pkg::FAST_PERIODS
                      : clk_speed_pkg::STD_PERIODS;

  always_comb begin
    if (cnt_reg >= limit - 4'h1) begin
      cnt_next = 4'h0;
    end else begin
      cnt_next = cnt_reg + 4'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= 4'h0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign cycle_end = (cnt_reg >= limit - 4'h1);
endmodule

// ### rtl/clock_speed_ctrl.sv
// clock speed control register on AHB-Lite with machine cycle strobes
`timescale 1ns/1ps
module clock_speed_ctrl (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hardware_config_double,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic core_tick,
  output logic core_cycle_end,
  output logic [5:0] periph_cycle_end,
  output logic [5:0] periph_fast
);
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic strap_done_reg;
  logic strap_done_next;
  logic wr_pend_reg;
  logic wr_pend_next;
  logic [31:0] hrdata_reg;
  logic [31:0] hrdata_next;
  logic core_tick_reg;
  logic core_cycle_reg;
  logic [5:0] pcyc_reg;
  logic [5:0] pcyc_next;
  logic [5:0] pfast_reg;
  logic [5:0] pfast_next;
  logic [5:0] pslow;
  logic [5:0] pfast_set;
  logic half_tick;
  logic fast_active;
  logic fast_end;
  logic slow_end;
  logic addr_hit;

  assign addr_hit = (haddr[11:0] == clk_speed_pkg::CTRL_ADDR);

  always_comb begin
    ctrl_next = ctrl_reg;
    strap_done_next = 1'b1;
    wr_pend_next = 1'b0;
    hrdata_next = hrdata_reg;
    if (!strap_done_reg) begin
      ctrl_next[clk_speed_pkg::DOUBLE_BIT] = hardware_config_double;
    end
    if (wr_pend_reg) begin
      ctrl_next = hwdata[7:0] & clk_speed_pkg::CTRL_WRITE_MASK;
    end
    if (hsel && hready && htrans[1]) begin
      wr_pend_next = hwrite && addr_hit;
      if (!hwrite) begin
        hrdata_next = addr_hit ? {24'h0, ctrl_reg} : 32'h0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= clk_speed_pkg::CTRL_RESET;
      strap_done_reg <= 1'b0;
      wr_pend_reg <= 1'b0;
      hrdata_reg <= 32'h0;
    end else begin
      ctrl_reg <= ctrl_next;
      strap_done_reg <= strap_done_next;
      wr_pend_reg <= wr_pend_next;
      hrdata_reg <= hrdata_next;
    end
  end

  assign hrdata = hrdata_reg;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  osc_divider u_div (
    .hclk(hclk),
    .hresetn(hresetn),
    .fast_req(ctrl_reg[clk_speed_pkg::DOUBLE_BIT]),
    .half_tick(half_tick),
    .fast_active(fast_active)
  );

  cycle_counter u_fast (
    .hclk(hclk),
    .hresetn(hresetn),
    .fast(1'b1),
    .cycle_end(fast_end)
  );

  cycle_counter u_slow (
    .hclk(hclk),
    .hresetn(hresetn),
    .fast(1'b0),
    .cycle_end(slow_end)
  );

  // peripheral select bits sit at ctrl bits 1..6
  genvar g;
  generate
    for (g = 0; g < clk_speed_pkg::NUM_PERIPH; g++) begin : g_periph
      // set gives 12, clear gives 6 only while double speed is active (12 otherwise)
      assign pslow[g] = ctrl_reg[g + 1];
      assign pfast_set[g] = fast_active & ~pslow[g];
    end
  endgenerate

  always_comb begin
    pfast_next = pfast_set;
    for (int i = 0; i < clk_speed_pkg::NUM_PERIPH; i++) begin
      pcyc_next[i] = pfast_set[i] ? fast_end : slow_end;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      core_tick_reg <= 1'b0;
      core_cycle_reg <= 1'b0;
      pcyc_reg <= 6'h00;
      pfast_reg <= 6'h00;
    end else begin
      core_tick_reg <= half_tick;
      core_cycle_reg <= fast_active ? fast_end : slow_end;
      pcyc_reg <= pcyc_next;
      pfast_reg <= pfast_next;
    end
  end

  assign core_tick = core_tick_reg;
  assign core_cycle_end = core_cycle_reg;
  assign periph_cycle_end = pcyc_reg;
  assign periph_fast = pfast_reg;

  // standard mode: core strobe must follow the twelve-period counter
  property p_std_slow;
    @(posedge hclk) disable iff (!hresetn)
      !fast_active |=> core_cycle_end == $past(slow_end);
  endproperty
  a_std_slow: assert property (p_std_slow)
    else $error("core cycle not twelve periods in standard mode");

  property p_periph_gated;
    @(posedge hclk) disable iff (!hresetn)
      !fast_active |=> periph_fast == 6'h00;
  endproperty
  a_periph_gated: assert property (p_periph_gated)
    else $error("peripheral fast while in standard mode");

  property p_watchdog_polarity;
    @(posedge hclk) disable iff (!hresetn)
      (fast_active && !ctrl_reg[clk_speed_pkg::WATCHDOG_BIT])
        |=> periph_fast[5];
  endproperty
  a_watchdog_polarity: assert property (p_watchdog_polarity)
    else $error("watchdog not fast when select cleared");

  property p_timer_slow_when_set;
    @(posedge hclk) disable iff (!hresetn)
      ctrl_reg[clk_speed_pkg::FIRST_TIMER_BIT] |=> !periph_fast[0];
  endproperty
  a_timer_slow_when_set: assert property (p_timer_slow_when_set)
    else $error("first timer fast while select set");

  property p_reserved_zero;
    @(posedge hclk) disable iff (!hresetn)
      ctrl_reg[clk_speed_pkg::RESERVED_BIT] == 1'b0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bit set");

  sequence s_write_data;
    wr_pend_reg ##1 1'b1;
  endsequence
  property p_write_lands;
    @(posedge hclk) disable iff (!hresetn)
      wr_pend_reg |=> ctrl_reg == ($past(hwdata[7:0]) & 8'h7f);
  endproperty
  a_write_lands: assert property (p_write_lands)
    else $error("register write not stored");

  property p_core_fast_cycle;
    @(posedge hclk) disable iff (!hresetn)
      (fast_active && fast_end) [*2] |-> 1'b0;
  endproperty
  a_core_fast_cycle: assert property (p_core_fast_cycle)
    else $error("fast cycle end on consecutive clocks");

  property p_tick_bypass;
    @(posedge hclk) disable iff (!hresetn)
      fast_active |=> core_tick;
  endproperty
  a_tick_bypass: assert property (p_tick_bypass)
    else $error("no tick every clock when divider bypassed");

  property p_strap;
    @(posedge hclk) disable iff (!hresetn)
      (!strap_done_reg && !wr_pend_reg)
        |=> ctrl_reg[0] == $past(hardware_config_double);
  endproperty
  a_strap: assert property (p_strap)
    else $error("double-speed select not loaded from config");
endmodule

// ### tb/osc_model.sv
// crystal oscillator model that drives the block clock
`timescale 1ns/1ps
module osc_model #(
  parameter real HALF_NS = 10.0
) (
  output logic clk
);
  initial clk = 1'h0;
  // free running: a crystal never stops between transfers
  always #(HALF_NS) clk = ~clk;
endmodule

// ### tb/clock_speed_ctrl_test.sv
// register and cycle-rate tests for the clock speed control block
`timescale 1ns/1ps
module clock_speed_ctrl_test;
  localparam logic [11:0] RA = clk_speed_pkg::CTRL_ADDR;
  logic hclk;
  logic hresetn = 1'h0;
  logic hsel = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [31:0] hwdata = 32'h0;
  logic cfg = 1'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic core_tick;
  logic core_cycle_end;
  logic [5:0] periph_cycle_end;
  logic [5:0] periph_fast;
  logic [31:0] rd;
  logic [3:0] n;
  logic t;
  int mismatches = 0;
  int checked = 0;

  osc_model i_osc_model (.clk(hclk));
  clock_speed_ctrl i_clock_speed_ctrl (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hardware_config_double(cfg), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .core_tick(core_tick),
    .core_cycle_end(core_cycle_end), .periph_cycle_end(periph_cycle_end),
    .periph_fast(periph_fast));

  task automatic check(input string nm, input logic [31:0] s, e);
    checked++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic wrap_up;
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'h1;
    haddr <= {20'h0, a};
    htrans <= clk_speed_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    rd = hrdata;
  endtask

  task automatic do_reset(input logic c);
    cfg <= c;
    hresetn <= 1'h0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'h1;
    repeat (2) @(posedge hclk);
  endtask

  function automatic logic pick(input int b);
    return (b == 6) ? core_cycle_end : periph_cycle_end[b];
  endfunction

  // clocks between two strobes; bounded so a dead strobe still ends
  task automatic measure(input int b);
    int k;
    repeat (2) begin
      k = 0;
      do begin
        @(posedge hclk);
        k++;
      end while (pick(b) !== 1'h1 && k < 40);
    end
    n = k[3:0];
  endtask

  initial begin
    #400000;
    mismatches++;
    wrap_up;
  end

  initial begin
    do_reset(1'h0);
    bus(1'h0, RA, 32'h0);
    check("reset value", rd, 32'h0);
    check("okay resp", hresp, 1'h0);
    measure(6);
    check("std core", n, clk_speed_pkg::STD_PERIODS);
    t = core_tick;
    @(posedge hclk);
    check("std tick", core_tick ^ t, 1'h1);
    bus(1'h1, RA, 32'h7e);
    bus(1'h0, RA, 32'h0);
    check("kept selects", rd, 32'h7e);
    check("std periph", periph_fast, 6'h0);
    measure(0);
    check("std periph", n, clk_speed_pkg::STD_PERIODS);
    // reserved top bit written high on purpose: must not stick
    bus(1'h1, RA, 32'hff);
    bus(1'h0, RA, 32'h0);
    check("reserved bit", rd, 32'h7f);
    measure(6);
    check("fast core", n, clk_speed_pkg::FAST_PERIODS);
    @(posedge hclk);
    check("fast tick", core_tick, 1'h1);
    check("set is slow", periph_fast, 6'h0);
    measure(5);
    check("slow wdog", n, clk_speed_pkg::STD_PERIODS);
    bus(1'h1, RA, 32'h1);
    repeat (4) @(posedge hclk);
    check("all fast", periph_fast, 6'h3f);
    for (int i = 0; i < 6; i++) begin
      measure(i);
      check("fast periph", n, clk_speed_pkg::FAST_PERIODS);
      bus(1'h1, RA, 32'h1 | (32'h2 << i));
      repeat (4) @(posedge hclk);
      check("one slow", periph_fast, 6'h3f & ~(6'h1 << i));
    end
    bus(1'h1, RA + 12'h4, 32'h0);
    bus(1'h0, RA + 12'h4, 32'h0);
    check("unmapped read", rd, 32'h0);
    bus(1'h0, RA, 32'h0);
    check("unmapped write", rd, 32'h41);
    do_reset(1'h1);
    bus(1'h0, RA, 32'h0);
    check("config reset", rd, 32'h1);
    measure(6);
    check("config fast", n, clk_speed_pkg::FAST_PERIODS);
    wrap_up;
  end
endmodule
